// ===== dacce_pkg.sv
// package: register map and field layout of the converter channel enable block
package dacce_pkg;
    // register byte offsets (full addresses as printed)
    localparam logic [31:0] DACCE_SET_OFFSET = 32'h4003C010;
    localparam logic [31:0] DACCE_CLR_OFFSET = 32'h4003C014;
    localparam logic [31:0] DACCE_STS_OFFSET = 32'h4003C018;
    // channel bit positions
    localparam int DACCE_CH_ZERO_POS = 0;
    localparam int DACCE_CH_ONE_POS = 1;
    localparam int DACCE_NUM_CH = 2;
    // reset value of the enable bits
    localparam logic [1:0] DACCE_ENABLE_RESET = 2'h0;
    // register bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dacce_req_t;
endpackage

// ===== dacce_channel_enable.sv
// converter channel enable set/clear/status registers
//
// How it works
// - a one written to the set register enables that channel; zeros change nothing
// - a one written to the clear register disables that channel; zeros change nothing
// - set and clear writes are ignored while write protection is on
// - read-only status register: channel zero at bit 0, channel one at bit 1
// - status bits read one while enabled, zero while disabled
`timescale 1ns/1ps
module dacce_channel_enable (
    input wire logic clock_in, // 100 MHz clock
    input wire logic sys_rst_in, // synchronous active-high reset
    input wire dacce_pkg::dacce_req_t bus_in, // address, data and strobes
    input wire logic write_protect_on_in, // write protection enable level
    output logic [31:0] rdata_out, // read data, cycle after read strobe
    output logic [1:0] channel_enable_out // per-channel enable to the converter
);
    import dacce_pkg::*;

    // ************************************************************
    // storage
    // ************************************************************
    // one enable flop per channel, plus the registered read word, so that
    // the bus sees read data exactly one cycle after its strobe
    logic [1:0] enable_reg;
    logic [1:0] enable_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // ************************************************************
    // address decode
    // ************************************************************
    // the full address is compared, so any alias of the block reads as unmapped
    logic hit_set;
    logic hit_clr;
    logic hit_sts;
    assign hit_set = (bus_in.addr == DACCE_SET_OFFSET);
    assign hit_clr = (bus_in.addr == DACCE_CLR_OFFSET);
    assign hit_sts = (bus_in.addr == DACCE_STS_OFFSET);

    // ************************************************************
    // write qualification
    // ************************************************************
    // protection gates both write-only registers alike; its level is taken
    // at the write edge itself, so software must settle it a cycle ahead
    logic wr_ok;
    logic set_wr;
    logic clr_wr;
    logic [1:0] wdata_bits;
    logic [1:0] set_mask;
    logic [1:0] clr_mask;
    assign wr_ok = bus_in.wr && !write_protect_on_in;
    assign set_wr = wr_ok && hit_set;
    assign clr_wr = wr_ok && hit_clr;

    // only the two channel positions are looked at; reserved bits are dropped
    assign wdata_bits = {bus_in.wdata[DACCE_CH_ONE_POS], bus_in.wdata[DACCE_CH_ZERO_POS]};
    assign set_mask = set_wr ? wdata_bits : 2'h0;
    assign clr_mask = clr_wr ? wdata_bits : 2'h0;

    // ************************************************************
    // enable state
    // ************************************************************
    // set and clear never share a cycle since they sit at different addresses;
    // should they ever meet, the clear wins, the safer outcome for an output
    // nothing here tracks conversions, so a disable mid-conversion is unguarded
    for (genvar ch = 0; ch < DACCE_NUM_CH; ch = ch + 1) begin : g_chan
        // a zero bit in both masks keeps the channel as it is
        assign enable_next[ch] = (enable_reg[ch] | set_mask[ch]) & ~clr_mask[ch];
    end

    // the reset value clears both channels, so no output starts enabled
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            enable_reg <= DACCE_ENABLE_RESET;
        end else begin
            enable_reg <= enable_next;
        end
    end

    // the converter sees the enable flops directly, with no extra stage
    assign channel_enable_out = enable_reg;

    // ************************************************************
    // read path
    // ************************************************************
    // status word: each channel lands at its own bit position, all else zero
    logic [31:0] status_word;
    logic rd_sts;
    assign status_word = (32'(enable_reg[0]) << DACCE_CH_ZERO_POS)
        | (32'(enable_reg[1]) << DACCE_CH_ONE_POS);
    assign rd_sts = bus_in.rd && hit_sts;

    // unmapped, write-only and idle cycles read as zero, which lets an
    // upstream read mux simply OR its slaves together
    assign rdata_next = rd_sts ? status_word : 32'h0;

    // the read word stands for one cycle only; it is cleared right after
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_out = rdata_reg;

    // ************************************************************
    // checks
    // ************************************************************
    // every property runs on the one clock and stands down while in reset,
    // except the reset checks, which must see the reset cycles themselves

    // an accepted set write turns on every channel whose bit was one
    a_set_enables: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.wr && hit_set && !write_protect_on_in |=>
        ((enable_reg & $past(bus_in.wdata[1:0])) == $past(bus_in.wdata[1:0])))
        else $error("set write did not enable channel");

    // an accepted clear write turns off every channel whose bit was one
    a_clear_disables: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.wr && hit_clr && !write_protect_on_in |=>
        ((enable_reg & $past(bus_in.wdata[1:0])) == 2'h0))
        else $error("clear write did not disable channel");

    // while protection is on, nothing may move the enables
    a_protect_holds: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        write_protect_on_in |=> $stable(enable_reg))
        else $error("enable changed under write protection");

    // only a set or clear write may move the enables
    a_idle_holds: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !(bus_in.wr && (hit_set || hit_clr)) |=> $stable(enable_reg))
        else $error("enable changed without a write");

    // zero bits of a clear write leave their channels alone
    a_zero_bits_keep: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.wr && hit_clr |=>
        ((enable_reg & ~$past(bus_in.wdata[1:0])) == ($past(enable_reg) & ~$past(bus_in.wdata[1:0]))))
        else $error("clear write touched a zero bit");

    // a status read returns the enables as they stood at the read edge
    a_status_read: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.rd && hit_sts |=> rdata_out == {30'h0, $past(enable_reg)})
        else $error("status read mismatch");

    // reserved bits of the read word are always zero
    a_reserved_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        rdata_out[31:2] == 30'h0)
        else $error("reserved status bits not zero");

    // reset leaves both channels off
    a_reset_clears: assert property (@(posedge clock_in)
        sys_rst_in |=> enable_reg == 2'h0)
        else $error("reset did not clear enables");

    // a set write, protected or not, never turns a channel off
    a_set_only_adds: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.wr && hit_set |=> ((enable_reg & $past(enable_reg)) == $past(enable_reg)))
        else $error("set write disabled a channel");

    // zero bits of a set write leave their channels alone
    a_set_zero_keep: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.wr && hit_set |=>
        ((enable_reg & ~$past(wdata_bits)) == ($past(enable_reg) & ~$past(wdata_bits))))
        else $error("set write touched a zero bit");

    // a clear write, protected or not, never turns a channel on
    a_clear_no_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.wr && hit_clr |=> ((enable_reg & ~$past(enable_reg)) == 2'h0))
        else $error("clear write enabled a channel");

    // the status register is read-only: a write there changes nothing
    a_status_wr_ignored: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.wr && hit_sts |=> $stable(enable_reg))
        else $error("status write changed an enable");

    // a read alone never changes the enable state
    a_read_keeps: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.rd && !bus_in.wr |=> $stable(enable_reg))
        else $error("read changed an enable");

    // outside a status read the read word is zero
    a_idle_rdata_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !rd_sts |=> rdata_out == 32'h0)
        else $error("read data not zero outside a status read");

    // each channel shows up at its own bit position
    a_status_bits: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        rd_sts |=> (rdata_out[DACCE_CH_ZERO_POS] == $past(enable_reg[0]))
            && (rdata_out[DACCE_CH_ONE_POS] == $past(enable_reg[1])))
        else $error("status bit position mismatch");

    // reset also clears the read word
    a_reset_rdata: assert property (@(posedge clock_in)
        sys_rst_in |=> rdata_out == 32'h0)
        else $error("reset did not clear read data");

    // ************************************************************
    // coverage of the main scenarios
    // ************************************************************
    // both channels switched on in one write
    c_set_write: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        wr_ok && hit_set && bus_in.wdata[1:0] == 2'h3);

    // a clear that actually has something to turn off
    c_clear_write: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        wr_ok && hit_clr && enable_reg != 2'h0);

    // a set write refused by protection
    c_protected_write: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.wr && write_protect_on_in && hit_set);

    // a status read with both channels on
    c_status_read: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        bus_in.rd && hit_sts && enable_reg == 2'h3);

    // a status read right behind an accepted set write
    c_back_to_back: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        set_wr ##1 rd_sts);
endmodule // dacce_channel_enable

// ===== tb_top.sv
// testbench for the converter channel enable block
`timescale 1ns/1ps
module tb_top;
    import dacce_pkg::*;
    localparam logic [31:0] SET_A = DACCE_SET_OFFSET;
    localparam logic [31:0] CLR_A = DACCE_CLR_OFFSET;
    localparam logic [31:0] STS_A = DACCE_STS_OFFSET;
    localparam logic [31:0] BAD_A = 32'h4003C01C;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wp = 1'b0;
    dacce_req_t bus = '0;
    logic [31:0] rdata;
    logic [1:0] en;
    int error_cnt = 0;
    int checks = 0;
    dacce_channel_enable dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .bus_in(bus),
        .write_protect_on_in(wp), .rdata_out(rdata), .channel_enable_out(en));
    // 100 MHz clock
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle strobe; results are looked at just after the taking edge
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock_in);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clock_in);
        bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
        #1;
    endtask
    // read data only stands in the cycle after the strobe, zero the cycle after
    task automatic read_chk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] e);
        acc(1'b0, a, 32'h0);
        chk("read data", exp, rdata);
        chk("enable", {30'h0, e}, {30'h0, en});
        @(posedge clock_in);
        #1;
        chk("read idle", 32'h0, rdata);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence: zeros written never change a channel, high bits are ignored;
    // nothing converts in this bench, so every disable keeps the software rule
    initial begin
        repeat (8) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        read_chk(STS_A, 32'h0, 2'h0);
        acc(1'b1, SET_A, 32'hFFFFFFFD);
        read_chk(STS_A, 32'h1, 2'h1);
        acc(1'b1, SET_A, 32'h2);
        read_chk(STS_A, 32'h3, 2'h3);
        acc(1'b1, CLR_A, 32'h1);
        read_chk(STS_A, 32'h2, 2'h2);
        $display("set and clear test done");
        @(posedge clock_in);
        wp <= 1'b1;
        acc(1'b1, SET_A, 32'h1);
        acc(1'b1, CLR_A, 32'h2);
        read_chk(STS_A, 32'h2, 2'h2);
        @(posedge clock_in);
        wp <= 1'b0;
        acc(1'b1, STS_A, 32'h3);
        acc(1'b1, BAD_A, 32'h3);
        read_chk(SET_A, 32'h0, 2'h2);
        read_chk(CLR_A, 32'h0, 2'h2);
        read_chk(BAD_A, 32'h0, 2'h2);
        acc(1'b1, CLR_A, 32'h3);
        read_chk(STS_A, 32'h0, 2'h0);
        $display("protect and map test done");
        // back-to-back strobes: set, status read, clear with no gap
        @(posedge clock_in);
        bus <= '{addr: SET_A, wdata: 32'h1, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        bus <= '{addr: STS_A, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_in);
        bus <= '{addr: CLR_A, wdata: 32'h1, wr: 1'b1, rd: 1'b0};
        #1;
        chk("read after write", 32'h1, rdata);
        @(posedge clock_in);
        bus <= '0;
        #1;
        chk("enable after clear", 32'h0, {30'h0, en});
        $display("back to back test done");
        acc(1'b1, SET_A, 32'h3);
        read_chk(STS_A, 32'h3, 2'h3);
        @(posedge clock_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        #1;
        chk("enable in reset", 32'h0, {30'h0, en});
        read_chk(STS_A, 32'h0, 2'h0);
        $display("second reset test done");
        end_sim();
    end
    // watchdog: the sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clock_in);
        error_cnt++;
        end_sim();
    end
endmodule // tb_top
